// *** design/amp_edge_filter.sv ***
`timescale 1ns/1ns
`default_nettype none
module amp_edge_filter #(
    parameter int FILTER = 250000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin_n,
    output logic fall
);
    import amp_remote_pkg::*;

    logic meta_r;
    logic sync_r;
    logic stable_r;
    logic primed_r;
    logic [31:0] cnt_r;
    logic done;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
        end else begin
            meta_r <= pin_n;
            sync_r <= meta_r;
        end
    end

    assign done = (cnt_r == 32'(FILTER - 1));

    // ----------------------------------------
    // level filter
    // ----------------------------------------
    // RL19 bounce filter
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 32'h0;
        end else if ((sync_r == stable_r) && primed_r) begin
            cnt_r <= 32'h0;
        end else if (done) begin
            cnt_r <= 32'h0;
        end else begin
            cnt_r <= cnt_r + 32'h1;
        end
    end

    // first level taken silently: static low never fires
    // RL12 falling edge only
    always_ff @(posedge clk) begin
        if (rst) begin
            stable_r <= 1'b1;
            primed_r <= 1'b0;
            fall <= 1'b0;
        end else begin
            fall <= 1'b0;
            if (done) begin
                stable_r <= sync_r;
                primed_r <= 1'b1;
                fall <= primed_r && stable_r && !sync_r;
            end
        end
    end

endmodule : amp_edge_filter
`default_nettype wire

// *** design/amp_remote_cmd.sv ***
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// RL1 - commands end in one line feed
// RL2 - controller spaces commands 200 ms apart
// RL3 - nine command strings recognised
// RL4 - replies only to queries
// RL5 - operate query reports operate or standby
// RL6 - control query names one of four sources
// RL7 - health query without fault reports normal
// RL8 - health query reports fault with index
// RL9 - identification gives maker, model, serial
// RL10 - four active-high discrete status outputs
// RL11 - summary fault ORs every fault
// RL12 - discrete commands act on falling edge
// RL13 - discrete pulses 10 to 50 ms
// RL14 - toggle edge swaps local and discrete
// RL15 - discrete operate edge enters operate
// RL16 - power-on starts in local control
// RL17 - control changes only in standby
// RL18 - reset command clears latched fault
// RL19 - discrete inputs synchronised and filtered
// RL20 - unknown lines discarded silently
module amp_remote_cmd #(
    parameter int N_TEMP = 4,
    parameter int N_PSU = 4,
    parameter int FILTER = amp_remote_pkg::FILTER_CYCLES,
    parameter logic [191:0] ID_STRING = "MAKER0, MODEL0, 000\n",
    parameter logic [4:0] ID_LEN = 5'h14
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic MAINS_IN,
    input wire logic INTERLOCK_FAULT,
    input wire logic [N_TEMP-1:0] TEMP_FAULT,
    input wire logic [N_PSU-1:0] PSU_FAULT,
    input wire logic CTRL_FAULT,
    input wire logic REMOTE_TOGGLE_N,
    input wire logic OPERATE_CMD_N,
    output logic MAINS_ON_OUT,
    output logic OPERATE_OUT,
    output logic TTL_REMOTE_OUT,
    output logic SUMMARY_ALARM_OUT
);
    import amp_remote_pkg::*;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [63:0] buf_r;
    logic [3:0] len_r;
    logic over_r;
    logic operate_r;
    cp_t cp_r;
    logic [3:0] flt_r;
    logic [191:0] reply_r;
    logic [REPLY_LEN_W-1:0] reply_len_r;
    logic pin_meta_r;
    logic pin_sync_r;
    logic [N_TEMP+N_PSU+1:0] flt_meta_r;
    logic [N_TEMP+N_PSU+1:0] flt_sync_r;
    logic [3:0] flt_live;
    logic [1:0] pin_n, fall;
    logic acc, wr_cmd, rd_reply, mapped, lf, line_ok;
    logic h_remote, h_local, h_oper, h_stby, h_opq, h_idq, h_rst, h_cpq, h_hsq;
    logic query;
    logic [191:0] rpl_nxt;
    logic [4:0] rpl_len_nxt;
    logic [31:0] rd_nxt;
    assign acc = PSEL && PENABLE;
    assign mapped = (PADDR == ADDR_CMD) || (PADDR == ADDR_REPLY) || (PADDR == ADDR_STATUS);
    assign wr_cmd = acc && PWRITE && (PADDR == ADDR_CMD);
    assign rd_reply = acc && !PWRITE && (PADDR == ADDR_REPLY);
    assign PREADY = PENABLE;
    assign PSLVERR = acc && !mapped;
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
            flt_meta_r <= '0;
            flt_sync_r <= '0;
        end else begin
            pin_meta_r <= MAINS_IN;
            pin_sync_r <= pin_meta_r;
            flt_meta_r <= {CTRL_FAULT, PSU_FAULT, TEMP_FAULT, INTERLOCK_FAULT};
            flt_sync_r <= flt_meta_r;
        end
    end
    assign flt_live = {flt_sync_r[N_TEMP+N_PSU+1], |flt_sync_r[N_TEMP+N_PSU:N_TEMP+1],
                       |flt_sync_r[N_TEMP:1], flt_sync_r[0]};
    // ----------------------------------------
    // discrete command inputs
    // ----------------------------------------
    assign pin_n = {OPERATE_CMD_N, REMOTE_TOGGLE_N};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            // RL19 filter per input
            amp_edge_filter #(.FILTER(FILTER)) u_filt (
                .clk(CLK),
                .rst(SYS_RST),
                .pin_n(pin_n[gi]),
                .fall(fall[gi])
            );
        end
    endgenerate
    // ----------------------------------------
    // line assembly
    // ----------------------------------------
    assign lf = wr_cmd && (PWDATA[7:0] == LINE_FEED);
    assign line_ok = lf && !over_r;
    // RL1 line feed framing
    always_ff @(posedge CLK) begin
        if (SYS_RST || lf) begin
            buf_r <= 64'h0;
            len_r <= 4'h0;
            over_r <= 1'b0;
        end else if (wr_cmd) begin
            if (len_r == 4'(CMD_BYTES)) begin
                over_r <= 1'b1;
            end else begin
                buf_r <= {buf_r[55:0], PWDATA[7:0]};
                len_r <= len_r + 4'h1;
            end
        end
    end
    // RL3 command decode
    // RL20 no match, no action
    assign h_remote = line_ok && (buf_r == STR_REMOTE);
    assign h_local = line_ok && (buf_r == STR_LOCAL);
    assign h_oper = line_ok && (buf_r == STR_OPERATE);
    assign h_stby = line_ok && (buf_r == STR_STANDBY);
    assign h_opq = line_ok && (buf_r == STR_OPQUERY);
    assign h_idq = line_ok && (buf_r == STR_IDQUERY);
    assign h_rst = line_ok && (buf_r == STR_RESET);
    assign h_cpq = line_ok && (buf_r == STR_CPQUERY);
    assign h_hsq = line_ok && (buf_r == STR_HSQUERY);
    assign query = h_opq || h_idq || h_cpq || h_hsq;
    // ----------------------------------------
    // amplifier state
    // ----------------------------------------
    // RL16 local at power-on
    // RL17 standby-only changes
    // RL14 discrete toggle
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cp_r <= CP_LOCAL;
        end else if (!operate_r) begin
            if (fall[0] && (cp_r == CP_LOCAL)) begin
                cp_r <= CP_TTL;
            end else if (fall[0] && (cp_r == CP_TTL)) begin
                cp_r <= CP_LOCAL;
            end else if (h_remote) begin
                cp_r <= CP_LAN;
            end else if (h_local) begin
                cp_r <= CP_LOCAL;
            end
        end
    end
    // a fault forces standby; operate needs a clean latch
    // RL15 discrete operate
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            operate_r <= 1'b0;
        end else if (|flt_r) begin
            operate_r <= 1'b0;
        end else if (fall[1] && (cp_r == CP_TTL)) begin
            operate_r <= 1'b1;
        end else if (h_oper && (cp_r == CP_LAN)) begin
            operate_r <= 1'b1;
        end else if (h_stby && (cp_r == CP_LAN)) begin
            operate_r <= 1'b0;
        end
    end
    // set wins over the reset command
    // RL18 fault latch clear
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            flt_r <= 4'h0;
        end else if (h_rst) begin
            flt_r <= flt_live;
        end else begin
            flt_r <= flt_r | flt_live;
        end
    end
    // ----------------------------------------
    // reply builder
    // ----------------------------------------
    function automatic logic [7:0] low_index(input logic [15:0] v);
        logic [7:0] r;
        r = 8'h30;
        for (int i = 15; i >= 0; i--) begin
            if (v[i]) begin
                r = 8'(8'h30 + i);
            end
        end
        return r;
    endfunction : low_index
    always_comb begin
        rpl_nxt = 192'h0;
        rpl_len_nxt = 5'h0;
        if (h_opq) begin
            // RL5 operate state reply
            rpl_nxt = operate_r ? RPL_OPERATE : RPL_STANDBY;
            rpl_len_nxt = operate_r ? LEN_OPERATE : LEN_STANDBY;
        end else if (h_cpq) begin
            // RL6 control point reply
            case (cp_r)
                CP_LOCAL: {rpl_nxt, rpl_len_nxt} = {RPL_LOCAL, LEN_LOCAL};
                CP_GPIB: {rpl_nxt, rpl_len_nxt} = {RPL_GPIB, LEN_GPIB};
                CP_LAN: {rpl_nxt, rpl_len_nxt} = {RPL_LAN, LEN_LAN};
                default: {rpl_nxt, rpl_len_nxt} = {RPL_TTL, LEN_TTL};
            endcase
        end else if (h_idq) begin
            // RL9 identification reply
            {rpl_nxt, rpl_len_nxt} = {ID_STRING, ID_LEN};
        end else if (h_hsq) begin
            // RL8 fault priority and index
            if (flt_r[0]) begin
                {rpl_nxt, rpl_len_nxt} = {RPL_INTERLOCK, LEN_INTERLOCK};
            end else if (flt_r[1]) begin
                rpl_nxt = {RPL_TEMP[175:0], low_index(16'(flt_sync_r[N_TEMP:1])), LINE_FEED};
                rpl_len_nxt = LEN_INDEXED;
            end else if (flt_r[2]) begin
                rpl_nxt = {RPL_PSU[175:0],
                           low_index(16'(flt_sync_r[N_TEMP+N_PSU:N_TEMP+1])), LINE_FEED};
                rpl_len_nxt = LEN_INDEXED;
            end else if (flt_r[3]) begin
                {rpl_nxt, rpl_len_nxt} = {RPL_CTRL, LEN_CTRL};
            end else begin
                // RL7 normal health reply
                {rpl_nxt, rpl_len_nxt} = {RPL_SYS_OK, LEN_SYS_OK};
            end
        end
    end
    // first char in top byte
    // RL4 replies only on query
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            reply_r <= 192'h0;
            reply_len_r <= '0;
        end else if (query) begin
            reply_r <= rpl_nxt << (8 * (REPLY_BYTES - int'(rpl_len_nxt)));
            reply_len_r <= rpl_len_nxt;
        end else if (rd_reply && (reply_len_r != '0)) begin
            reply_r <= {reply_r[183:0], 8'h00};
            reply_len_r <= reply_len_r - 5'h1;
        end
    end
    // ----------------------------------------
    // apb read data, captured in setup
    // ----------------------------------------
    always_comb begin
        rd_nxt = 32'h0;
        case (PADDR)
            ADDR_REPLY: begin
                rd_nxt[7:0] = reply_r[191:184];
                rd_nxt[REPLY_VALID_BIT] = (reply_len_r != '0);
            end
            ADDR_STATUS: begin
                rd_nxt[ST_OPERATE] = operate_r;
                rd_nxt[ST_CP_LO +: 2] = cp_r;
                rd_nxt[ST_MAINS] = pin_sync_r;
                rd_nxt[ST_PENDING] = (reply_len_r != '0);
                rd_nxt[ST_INTERLOCK] = flt_r[0];
                rd_nxt[ST_TEMP] = flt_r[1];
                rd_nxt[ST_PSU] = flt_r[2];
                rd_nxt[ST_CTRL] = flt_r[3];
            end
            default: rd_nxt = 32'h0;
        endcase
    end
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            PRDATA <= 32'h0;
        end else if (PSEL && !PENABLE) begin
            PRDATA <= PWRITE ? 32'h0 : rd_nxt;
        end
    end
    // ----------------------------------------
    // discrete status outputs
    // ----------------------------------------
    // RL10 status outputs
    // RL11 summary alarm
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            MAINS_ON_OUT <= 1'b0;
            OPERATE_OUT <= 1'b0;
            TTL_REMOTE_OUT <= 1'b0;
            SUMMARY_ALARM_OUT <= 1'b0;
        end else begin
            MAINS_ON_OUT <= pin_sync_r;
            OPERATE_OUT <= operate_r;
            TTL_REMOTE_OUT <= (cp_r == CP_TTL);
            SUMMARY_ALARM_OUT <= |flt_r;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    sequence s_unknown_line;
        lf && !(h_remote || h_local || h_oper || h_stby || query || h_rst);
    endsequence
    property p_reply_cause;
        (reply_len_r > $past(reply_len_r)) |-> $past(query);
    endproperty
    a_reply_cause: assert property (p_reply_cause) else $error("reply without query"); // RL4
    property p_opq;
        (h_opq && operate_r) |=> (reply_len_r == LEN_OPERATE) && (reply_r[191:184] == 8'h41);
    endproperty
    a_opq: assert property (p_opq) else $error("wrong operate reply"); // RL5
    property p_cpq;
        (h_cpq && (cp_r == CP_TTL)) |=> (reply_len_r == LEN_TTL) && (reply_r[191:184] == 8'h54);
    endproperty
    a_cpq: assert property (p_cpq) else $error("wrong control reply"); // RL6
    property p_hs_ok;
        (h_hsq && (flt_r == 4'h0)) |=> (reply_len_r == LEN_SYS_OK);
    endproperty
    a_hs_ok: assert property (p_hs_ok) else $error("wrong normal reply"); // RL7
    property p_summary;
        ##1 (SUMMARY_ALARM_OUT == $past(|flt_r));
    endproperty
    a_summary: assert property (p_summary) else $error("summary mismatch"); // RL11
    property p_start_local;
        disable iff (1'b0) SYS_RST |=> (cp_r == CP_LOCAL) && !operate_r;
    endproperty
    a_start_local: assert property (p_start_local) else $error("not local after reset"); // RL16
    property p_hold_cp;
        operate_r |=> $stable(cp_r);
    endproperty
    a_hold_cp: assert property (p_hold_cp) else $error("control moved in operate"); // RL17
    property p_toggle;
        (fall[0] && !operate_r && (cp_r == CP_LOCAL)) |=> (cp_r == CP_TTL) ##1 TTL_REMOTE_OUT;
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle missed"); // RL14
    property p_ttl_oper;
        (fall[1] && (cp_r == CP_TTL) && (flt_r == 4'h0)) |=> operate_r ##1 OPERATE_OUT;
    endproperty
    a_ttl_oper: assert property (p_ttl_oper) else $error("discrete operate missed"); // RL15
    property p_rst_clear;
        (h_rst && (flt_live == 4'h0)) |=> (flt_r == 4'h0);
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("fault not cleared"); // RL18
    property p_discard;
        s_unknown_line |=> $stable(cp_r) && $stable(reply_len_r);
    endproperty
    a_discard: assert property (p_discard) else $error("unknown line acted on"); // RL20

endmodule : amp_remote_cmd
`default_nettype wire

// *** design/amp_remote_pkg.sv ***
package amp_remote_pkg;

    // ----------------------------------------
    // link and buffer sizes
    // ----------------------------------------
    localparam logic [7:0] LINE_FEED = 8'h0a;
    localparam int CMD_BYTES = 8;
    localparam int REPLY_BYTES = 24;
    localparam int REPLY_LEN_W = 5;

    // ----------------------------------------
    // apb register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_REPLY = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    // ----------------------------------------
    // status and reply register fields
    // ----------------------------------------
    localparam int ST_OPERATE = 0;
    localparam int ST_CP_LO = 1;
    localparam int ST_MAINS = 3;
    localparam int ST_PENDING = 4;
    localparam int ST_INTERLOCK = 5;
    localparam int ST_TEMP = 6;
    localparam int ST_PSU = 7;
    localparam int ST_CTRL = 8;
    localparam int REPLY_VALID_BIT = 8;

    // ----------------------------------------
    // command strings, right aligned
    // ----------------------------------------
    localparam logic [63:0] STR_REMOTE = "REMOTE";
    localparam logic [63:0] STR_LOCAL = "LOCAL";
    localparam logic [63:0] STR_OPERATE = 64'h414d505f4f4e;
    localparam logic [63:0] STR_STANDBY = 64'h414d505f4f4646;
    localparam logic [63:0] STR_OPQUERY = 64'h414d503f;
    localparam logic [63:0] STR_IDQUERY = "*IDN?";
    localparam logic [63:0] STR_RESET = "*RST";
    localparam logic [63:0] STR_CPQUERY = "CONTROL?";
    localparam logic [63:0] STR_HSQUERY = "STATUS?";

    // ----------------------------------------
    // reply strings, line feed included except in the indexed prefixes RPL_TEMP and RPL_PSU
    // ----------------------------------------
    localparam logic [191:0] RPL_OPERATE = 192'h414d505f4f4e0a;
    localparam logic [191:0] RPL_STANDBY = 192'h414d505f4f46460a;
    localparam logic [191:0] RPL_LOCAL = "LOCAL\n";
    localparam logic [191:0] RPL_GPIB = "GPIB\n";
    localparam logic [191:0] RPL_LAN = "LAN\n";
    localparam logic [191:0] RPL_TTL = "TTL\n";
    localparam logic [191:0] RPL_SYS_OK = "SYSTEM_OK\n";
    localparam logic [191:0] RPL_INTERLOCK = "Interlock External\n";
    localparam logic [191:0] RPL_TEMP = "Temperature ";
    localparam logic [191:0] RPL_PSU = "PowerSupply ";
    localparam logic [191:0] RPL_CTRL = "Control Fault\n";
    localparam logic [4:0] LEN_OPERATE = 5'h07;
    localparam logic [4:0] LEN_STANDBY = 5'h08;
    localparam logic [4:0] LEN_LOCAL = 5'h06;
    localparam logic [4:0] LEN_GPIB = 5'h05;
    localparam logic [4:0] LEN_LAN = 5'h04;
    localparam logic [4:0] LEN_TTL = 5'h04;
    localparam logic [4:0] LEN_SYS_OK = 5'h0a;
    localparam logic [4:0] LEN_INTERLOCK = 5'h13;
    localparam logic [4:0] LEN_INDEXED = 5'h0e;
    localparam logic [4:0] LEN_CTRL = 5'h0e;

    // ----------------------------------------
    // discrete input filter
    // ----------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int FILTER_TIME_US = 5000;
    localparam int FILTER_CYCLES = FILTER_TIME_US * CLK_MHZ;

    typedef enum logic [1:0] {CP_LOCAL, CP_GPIB, CP_LAN, CP_TTL} cp_t;

endpackage : amp_remote_pkg

// *** test/amp_discrete_driver.sv ***
`timescale 1ns/1ns
`default_nettype none
module amp_discrete_driver #(
    parameter int WIDTH = 40
) (
    input wire logic clk,
    input wire logic start_toggle,
    input wire logic start_operate,
    input wire logic bounce,
    output logic toggle_n,
    output logic operate_n
);
    // ----------------------------------------
    // low pulse timers
    // ----------------------------------------
    logic [7:0] tog_cnt_r = 8'h00;
    logic [7:0] op_cnt_r = 8'h00;
    always @(posedge clk) begin
        if (start_toggle) begin
            tog_cnt_r <= 8'(WIDTH);
        end else if (tog_cnt_r != 8'h00) begin
            tog_cnt_r <= tog_cnt_r - 8'h01;
        end
    end
    always @(posedge clk) begin
        if (start_operate) begin
            op_cnt_r <= 8'(WIDTH);
        end else if (op_cnt_r != 8'h00) begin
            op_cnt_r <= op_cnt_r - 8'h01;
        end
    end
    // ----------------------------------------
    // pin levels
    // ----------------------------------------
    // idle high; brief chatter at start
    assign toggle_n = (tog_cnt_r == 8'h00) || (bounce && tog_cnt_r > 8'(WIDTH - 4) && tog_cnt_r[0]);
    assign operate_n = (op_cnt_r == 8'h00) || (bounce && op_cnt_r > 8'(WIDTH - 4) && op_cnt_r[0]);
endmodule : amp_discrete_driver
`default_nettype wire

// *** test/amp_remote_cmd_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module amp_remote_cmd_test;
    import amp_remote_pkg::*;
    // ----------------------------------------
    // bench signals
    // ----------------------------------------
    // id text is arbitrary
    localparam logic [191:0] ID_TXT = "MKR1, MDL2, 042\n";
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic mains = 1'b0, ilk = 1'b0, ctrl = 1'b0;
    logic [3:0] temp = 4'h0, psu = 4'h0;
    logic go_tog = 1'b0, go_op = 1'b0, bounce = 1'b1;
    logic tog_n, op_n, mains_out, op_out, ttl_out, alarm_out;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;

    amp_remote_cmd #(.FILTER(8), .ID_STRING(ID_TXT), .ID_LEN(5'h10)) dut_u (
        .CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .MAINS_IN(mains), .INTERLOCK_FAULT(ilk), .TEMP_FAULT(temp), .PSU_FAULT(psu),
        .CTRL_FAULT(ctrl), .REMOTE_TOGGLE_N(tog_n), .OPERATE_CMD_N(op_n),
        .MAINS_ON_OUT(mains_out), .OPERATE_OUT(op_out), .TTL_REMOTE_OUT(ttl_out),
        .SUMMARY_ALARM_OUT(alarm_out));
    amp_discrete_driver #(.WIDTH(40)) peer_u (.clk(clk), .start_toggle(go_tog),
        .start_operate(go_op), .bounce(bounce), .toggle_n(tog_n), .operate_n(op_n));

    initial forever #10 clk = ~clk;
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [191:0] seen, input logic [191:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_count++;
            conclude();
        end
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic send(input logic [63:0] s, input logic [7:0] term);
        logic [31:0] rd;
        logic err;
        for (int i = 7; i >= 0; i--) begin
            if (s[8*i +: 8] != 8'h00) apb(1'b1, ADDR_CMD, {24'h0, s[8*i +: 8]}, rd, err);
        end
        apb(1'b1, ADDR_CMD, {24'h0, term}, rd, err);
        repeat (4) @(posedge clk); // scaled gap between lines
    endtask : send

    task automatic status(output logic [31:0] st);
        logic err;
        apb(1'b0, ADDR_STATUS, 32'h0, st, err);
    endtask : status

    task automatic query(input logic [63:0] cmd, input logic [191:0] exp, input string name);
        logic [31:0] rd;
        logic err;
        logic [191:0] txt;
        txt = '0;
        send(cmd, LINE_FEED);
        for (int i = 0; i < REPLY_BYTES; i++) begin
            apb(1'b0, ADDR_REPLY, 32'h0, rd, err);
            if (rd[REPLY_VALID_BIT] !== 1'b1) break;
            txt = {txt[183:0], rd[7:0]};
        end
        check(name, txt, exp);
    endtask : query

    task automatic pulse(input logic op);
        go_op <= op;
        go_tog <= !op;
        @(posedge clk);
        go_op <= 1'b0;
        go_tog <= 1'b0;
        repeat (60) @(posedge clk);
    endtask : pulse
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_power_on();
        logic [31:0] st;
        check("idle pins", {mains_out, op_out, ttl_out, alarm_out}, 4'h0);
        status(st);
        check("ctrl point", st[2:1], CP_LOCAL);
        query("CONTROL?", RPL_LOCAL, "local reply");
        query(STR_OPQUERY, RPL_STANDBY, "standby reply");
        query("STATUS?", RPL_SYS_OK, "normal reply");
        query("*IDN?", ID_TXT, "id reply");
        $display("test power_on done");
    endtask : t_power_on

    task automatic t_framing();
        logic [31:0] st;
        logic err;
        send(STR_OPQUERY, 8'h0d);
        status(st);
        check("no lf no reply", st[ST_PENDING], 1'b0);
        send("", LINE_FEED);
        send("BOGUS", LINE_FEED);
        status(st);
        check("junk silent", st[ST_PENDING:0], 5'h00);
        apb(1'b0, 8'h0c, 32'h0, st, err);
        check("unmapped", {err, st}, 33'h100000000);
        $display("test framing done");
    endtask : t_framing

    task automatic t_lan();
        logic [31:0] st;
        send("REMOTE", LINE_FEED);
        status(st);
        check("no reply to set", st[ST_PENDING], 1'b0);
        query("CONTROL?", RPL_LAN, "lan reply");
        send(STR_OPERATE, LINE_FEED);
        query(STR_OPQUERY, RPL_OPERATE, "operate reply");
        check("operate pin", op_out, 1'b1);
        send("LOCAL", LINE_FEED);
        query("CONTROL?", RPL_LAN, "held in operate");
        send(STR_STANDBY, LINE_FEED);
        query(STR_OPQUERY, RPL_STANDBY, "standby again");
        send("LOCAL", LINE_FEED);
        query("CONTROL?", RPL_LOCAL, "back to local");
        $display("test lan done");
    endtask : t_lan

    task automatic t_discrete();
        mains <= 1'b1;
        pulse(1'b0);
        check("mains pin", mains_out, 1'b1);
        check("ttl pin", ttl_out, 1'b1);
        query("CONTROL?", RPL_TTL, "one event per pulse");
        pulse(1'b1);
        check("ttl operate", op_out, 1'b1);
        query(STR_OPQUERY, RPL_OPERATE, "ttl operate reply");
        pulse(1'b0);
        check("toggle in operate", ttl_out, 1'b1);
        ilk <= 1'b1;
        repeat (8) @(posedge clk);
        ilk <= 1'b0;
        repeat (8) @(posedge clk);
        send("*RST", LINE_FEED);
        pulse(1'b0);
        check("ttl off", ttl_out, 1'b0);
        $display("test discrete done");
    endtask : t_discrete

    task automatic t_faults();
        logic [191:0] exp;
        for (int k = 0; k < 4; k++) begin
            ilk <= (k == 0);
            temp <= (k == 1) ? 4'h4 : 4'h0;
            psu <= (k == 2) ? 4'h2 : 4'h0;
            ctrl <= (k == 3);
            repeat (8) @(posedge clk);
            check("alarm pin", alarm_out, 1'b1);
            case (k)
                0: exp = RPL_INTERLOCK;
                1: exp = {RPL_TEMP[175:0], 8'h32, LINE_FEED};
                2: exp = {RPL_PSU[175:0], 8'h31, LINE_FEED};
                default: exp = RPL_CTRL;
            endcase
            query("STATUS?", exp, "fault reply");
            {ilk, temp, psu, ctrl} <= 10'h000;
            repeat (8) @(posedge clk);
            check("alarm latched", alarm_out, 1'b1);
            send("*RST", LINE_FEED);
            check("alarm cleared", alarm_out, 1'b0);
        end
        query("STATUS?", RPL_SYS_OK, "normal again");
        $display("test faults done");
    endtask : t_faults

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_power_on();
        t_framing();
        t_lan();
        t_discrete();
        t_faults();
        conclude();
    end
endmodule : amp_remote_cmd_test
`default_nettype wire
